// ### pkg/ppd_pkg.sv
// Shared constants, register map and state encoding of the pin waveform engine.
package ppd_pkg;

  // Clock and timing.
  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_UNIT_NS = 2000;
  localparam int PREP_NS       = 4000;
  localparam int PWM_CYCLE_NS  = 400000;
  localparam int SLOTS_PER_CYC = 255;

  localparam logic [15:0] PULSE_UNIT_CLKS =
    16'((PULSE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [15:0] PREP_CLKS =
    16'((PREP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  // Slot length rounds down so a whole cycle never runs past its unit.
  localparam logic [15:0] SLOT_CLKS =
    16'(PWM_CYCLE_NS / (SLOTS_PER_CYC * CLK_PERIOD_NS));
  localparam logic [7:0]  SLOT_LAST = 8'(SLOTS_PER_CYC - 1);
  localparam logic [8:0]  DUTY_FULL = 9'h0ff;

  // Register bus.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_PIN    = 8'h08;
  localparam logic [7:0] OFS_PERIOD = 8'h0c;
  localparam logic [7:0] OFS_DUTY   = 8'h10;
  localparam logic [7:0] OFS_CYCLES = 8'h14;
  localparam logic [7:0] OFS_OUT    = 8'h18;
  localparam logic [7:0] OFS_DIR    = 8'h1c;
  localparam logic [7:0] OFS_LEVEL  = 8'h20;

  // Field positions.
  localparam int CMD_PULSE_BIT = 0;
  localparam int CMD_PWM_BIT   = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;

  // Reset values.
  localparam logic [3:0]  PIN_RST    = 4'h0;
  localparam logic [15:0] PERIOD_RST = 16'h0000;
  localparam logic [7:0]  DUTY_RST   = 8'h00;
  localparam logic [7:0]  CYCLES_RST = 8'h00;
  localparam logic [15:0] OUT_RST    = 16'h0000;
  localparam logic [15:0] DIR_RST    = 16'h0000;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PREP = 3'b001,
    ST_HOLD = 3'b010,
    ST_PWM  = 3'b011
  } ppd_state_e;

endpackage

// ### rtl/ppd_density_mod.sv
// Density modulator: modulo-255 accumulator whose carry is the output bit.
`timescale 1ns/1ps
module ppd_density_mod (
  input  wire logic       clk,     // system clock
  input  wire logic       rst_n,   // synchronised reset, active low
  input  wire logic       clr,     // restart accumulator from zero
  input  wire logic       step,    // advance one bit slot
  input  wire logic [7:0] duty,    // ones per 255 slots
  output logic            bit_o    // current slot level
);
  import ppd_pkg::*;

  typedef struct packed {
    logic [7:0] acc;
    logic       bit_q;
  } ppd_mod_s;

  localparam ppd_mod_s MOD_RST = '{acc: 8'h00, bit_q: 1'b0};

  ppd_mod_s   q_r;
  ppd_mod_s   q_nxt;
  logic [8:0] sum;

  // The carry threshold is 255, not 256, so that exactly duty ones fall in
  // every run of 255 slots.
  always_comb begin
    q_nxt = q_r;
    sum   = {1'b0, (clr ? 8'h00 : q_r.acc)} + {1'b0, duty};
    if (step) begin
      if (sum >= DUTY_FULL) begin
        q_nxt.bit_q = 1'b1;
        q_nxt.acc   = 8'(sum - DUTY_FULL);
      end else begin
        q_nxt.bit_q = 1'b0;
        q_nxt.acc   = sum[7:0];
      end
    end else if (clr) begin
      q_nxt.acc = 8'h00;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= MOD_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign bit_o = q_r.bit_q;

endmodule

// ### rtl/ppd_pin_waveform.sv
// Pin waveform engine: timed single pulse and density-modulated burst.
//
// Overview of operation
// - A 4-bit pin index picks one of sixteen pins for the operation.
// - Pulse length is a 16-bit count of fixed time units.
// - Pulse forces output, toggles, holds the duration, toggles back.
// - Pulse polarity follows the output latch: low gives positive pulse.
// - Enabling the driver first presents the existing output latch value.
// - A short preparation wait precedes the first toggle.
// - Burst sets the pin to output, back to input after all cycles.
// - Burst takes an 8-bit duty, average level duty over 255.
// - Burst length is an 8-bit count of fixed-length cycles.
// - Each cycle carries ones in the proportion duty over 255.
// - Burst is a fast density sequence of short slots, not one split.
// - After the burst the direction bit is cleared to release the pin.
`timescale 1ns/1ps
module ppd_pin_waveform (
  input  wire logic                       ref_clk,  // system clock
  input  wire logic                       rst_n,    // async reset, low
  input  wire logic [ppd_pkg::ADDR_W-1:0] addr,     // register byte address
  input  wire logic [ppd_pkg::DATA_W-1:0] wr_data,  // write data
  input  wire logic                       wr_en,    // write strobe
  input  wire logic                       rd_en,    // read strobe
  output logic      [ppd_pkg::DATA_W-1:0] rd_data,  // read data, next cycle
  input  wire logic [15:0]                pin_in,   // pin levels
  output logic      [15:0]                pin_out,  // pin drive levels
  output logic      [15:0]                pin_oe,   // pin drive enables
  output logic                            busy,     // operation running
  output logic                            done      // operation ended
);
  import ppd_pkg::*;

  typedef struct packed {
    logic [15:0]       pin_meta;
    logic [15:0]       pin_sync;
    logic [3:0]        pin_sel;
    logic [15:0]       period;
    logic [7:0]        duty;
    logic [7:0]        cycles;
    logic [15:0]       out_latch;
    logic [15:0]       dir;
    logic              done_sticky;
    ppd_state_e        st;
    logic [15:0]       tick;
    logic [15:0]       units;
    logic [7:0]        slot;
    logic [7:0]        cyc;
    logic [15:0]       pin_o;
    logic              busy;
    logic              done;
    logic [DATA_W-1:0] rd_data;
  } ppd_core_s;

  localparam ppd_core_s CORE_RST = '{
    pin_meta:    16'h0000,
    pin_sync:    16'h0000,
    pin_sel:     PIN_RST,
    period:      PERIOD_RST,
    duty:        DUTY_RST,
    cycles:      CYCLES_RST,
    out_latch:   OUT_RST,
    dir:         DIR_RST,
    done_sticky: 1'b0,
    st:          ST_IDLE,
    tick:        16'h0000,
    units:       16'h0000,
    slot:        8'h00,
    cyc:         8'h00,
    pin_o:       OUT_RST,
    busy:        1'b0,
    done:        1'b0,
    rd_data:     32'h0000_0000
  };

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [15:0] put_bit(input logic [15:0] v,
                                          input logic [3:0]  idx,
                                          input logic        val);
    logic [15:0] r;
    r      = v;
    r[idx] = val;
    return r;
  endfunction

  function automatic logic [15:0] flip_bit(input logic [15:0] v,
                                           input logic [3:0]  idx);
    return put_bit(v, idx, ~v[idx]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic [1:0] rst_sync_r;
  logic       core_rst_n;

  // Reset is applied at once but released only after two clean edges.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_r <= 2'b00;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign core_rst_n = rst_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////

  ppd_core_s q_r;
  ppd_core_s q_nxt;
  logic      go_pulse;
  logic      go_pwm;
  logic      finish;
  logic      mod_clr;
  logic      mod_step;
  logic      mod_bit;

  ppd_density_mod u_mod (
    .clk   (ref_clk),
    .rst_n (core_rst_n),
    .clr   (mod_clr),
    .step  (mod_step),
    .duty  (q_r.duty),
    .bit_o (mod_bit)
  );

  always_comb begin
    q_nxt    = q_r;
    finish   = 1'b0;
    mod_clr  = 1'b0;
    mod_step = 1'b0;
    q_nxt.done    = 1'b0;
    q_nxt.rd_data = '0;

    q_nxt.pin_meta = pin_in;
    q_nxt.pin_sync = q_r.pin_meta;

    // Starts are taken only while idle; a busy engine ignores them.
    go_pulse = wr_en && (addr == OFS_CMD) && wr_data[CMD_PULSE_BIT] &&
               (q_r.st == ST_IDLE);
    go_pwm   = wr_en && (addr == OFS_CMD) && wr_data[CMD_PWM_BIT] &&
               !wr_data[CMD_PULSE_BIT] && (q_r.st == ST_IDLE);

    // Operand and pin registers are frozen while an operation runs, so the
    // engine never sees its pin or operands change under it.
    if (wr_en && (q_r.st == ST_IDLE)) begin
      case (addr)
        OFS_PIN:    q_nxt.pin_sel   = wr_data[3:0];
        OFS_PERIOD: q_nxt.period    = wr_data[15:0];
        OFS_DUTY:   q_nxt.duty      = wr_data[7:0];
        OFS_CYCLES: q_nxt.cycles    = wr_data[7:0];
        OFS_OUT:    q_nxt.out_latch = wr_data[15:0];
        OFS_DIR:    q_nxt.dir       = wr_data[15:0];
        default:    q_nxt.pin_sel   = q_r.pin_sel;
      endcase
    end

    if (wr_en && (addr == OFS_STATUS) && wr_data[STAT_DONE_BIT]) begin
      q_nxt.done_sticky = 1'b0;
    end

    if (rd_en) begin
      case (addr)
        OFS_STATUS: begin
          q_nxt.rd_data[STAT_BUSY_BIT] = q_r.busy;
          q_nxt.rd_data[STAT_DONE_BIT] = q_r.done_sticky;
        end
        OFS_PIN:    q_nxt.rd_data[3:0]  = q_r.pin_sel;
        OFS_PERIOD: q_nxt.rd_data[15:0] = q_r.period;
        OFS_DUTY:   q_nxt.rd_data[7:0]  = q_r.duty;
        OFS_CYCLES: q_nxt.rd_data[7:0]  = q_r.cycles;
        OFS_OUT:    q_nxt.rd_data[15:0] = q_r.out_latch;
        OFS_DIR:    q_nxt.rd_data[15:0] = q_r.dir;
        OFS_LEVEL:  q_nxt.rd_data[15:0] = q_r.pin_sync;
        default:    q_nxt.rd_data       = '0;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////

    case (q_r.st)
      ST_IDLE: begin
        if (go_pulse) begin
          // The driver comes on showing whatever the latch holds, which
          // can glitch a pulled-up input pin before the timed part.
          q_nxt.dir  = put_bit(q_r.dir, q_r.pin_sel, 1'b1);
          q_nxt.tick = PREP_CLKS - 16'h0001;
          q_nxt.st   = ST_PREP;
        end else if (go_pwm) begin
          if (q_r.cycles == 8'h00) begin
            q_nxt.dir = put_bit(q_r.dir, q_r.pin_sel, 1'b0);
            finish    = 1'b1;
          end else begin
            q_nxt.dir  = put_bit(q_r.dir, q_r.pin_sel, 1'b1);
            q_nxt.tick = SLOT_CLKS - 16'h0001;
            q_nxt.slot = 8'h00;
            q_nxt.cyc  = q_r.cycles;
            q_nxt.st   = ST_PWM;
            mod_clr    = 1'b1;
            mod_step   = 1'b1;
          end
        end
      end
      ST_PREP: begin
        if (q_r.tick != 16'h0000) begin
          q_nxt.tick = q_r.tick - 16'h0001;
        end else if (q_r.period == 16'h0000) begin
          finish = 1'b1;
        end else begin
          // Inverting the latch makes polarity follow its prior value.
          q_nxt.out_latch = flip_bit(q_r.out_latch, q_r.pin_sel);
          q_nxt.units     = q_r.period;
          q_nxt.tick      = PULSE_UNIT_CLKS - 16'h0001;
          q_nxt.st        = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (q_r.tick != 16'h0000) begin
          q_nxt.tick = q_r.tick - 16'h0001;
        end else if (q_r.units == 16'h0001) begin
          q_nxt.out_latch = flip_bit(q_r.out_latch, q_r.pin_sel);
          finish          = 1'b1;
        end else begin
          q_nxt.units = q_r.units - 16'h0001;
          q_nxt.tick  = PULSE_UNIT_CLKS - 16'h0001;
        end
      end
      ST_PWM: begin
        if (q_r.tick != 16'h0000) begin
          q_nxt.tick = q_r.tick - 16'h0001;
        end else begin
          q_nxt.tick = SLOT_CLKS - 16'h0001;
          if (q_r.slot == SLOT_LAST) begin
            q_nxt.slot = 8'h00;
            if (q_r.cyc == 8'h01) begin
              // Releasing the driver lets the filter capacitor hold.
              q_nxt.dir = put_bit(q_r.dir, q_r.pin_sel, 1'b0);
              finish    = 1'b1;
            end else begin
              q_nxt.cyc = q_r.cyc - 8'h01;
              mod_step  = 1'b1;
            end
          end else begin
            q_nxt.slot = q_r.slot + 8'h01;
            mod_step   = 1'b1;
          end
        end
      end
      default: begin
        q_nxt.st = ST_IDLE;
      end
    endcase

    // The sticky flag is set after the clear above, so an ending that
    // meets a clear in the same cycle is kept.
    if (finish) begin
      q_nxt.st          = ST_IDLE;
      q_nxt.done        = 1'b1;
      q_nxt.done_sticky = 1'b1;
    end

    q_nxt.busy  = (q_nxt.st != ST_IDLE);
    q_nxt.pin_o = q_nxt.out_latch;
    // The first burst cycle shows the latch, because the modulator's bit is
    // stale until its first slot step has been registered.
    if ((q_nxt.st == ST_PWM) && (q_r.st == ST_PWM)) begin
      q_nxt.pin_o = put_bit(q_nxt.out_latch, q_r.pin_sel, mod_bit);
    end
  end

  always_ff @(posedge ref_clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      q_r <= CORE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  assign rd_data = q_r.rd_data;
  assign pin_out = q_r.pin_o;
  assign pin_oe  = q_r.dir;
  assign busy    = q_r.busy;
  assign done    = q_r.done;

endmodule

// ### bench/ppd_pin_waveform_asserts.sv
// Port-level checks of the pin waveform engine.
`timescale 1ns/1ps
module ppd_checker (
  input wire logic                       ref_clk,  // system clock
  input wire logic                       rst_n,    // raw reset, low
  input wire logic [ppd_pkg::ADDR_W-1:0] addr,     // register address
  input wire logic [ppd_pkg::DATA_W-1:0] wr_data,  // write data
  input wire logic                       wr_en,    // write strobe
  input wire logic                       rd_en,    // read strobe
  input wire logic [ppd_pkg::DATA_W-1:0] rd_data,  // read data
  input wire logic [15:0]                pin_in,   // pin levels
  input wire logic [15:0]                pin_out,  // drive levels
  input wire logic [15:0]                pin_oe,   // drive enables
  input wire logic                       busy,     // running
  input wire logic                       done      // finished
);
  import ppd_pkg::*;
  localparam logic [31:0] PREP_C  = 32'h1 + 32'(PREP_CLKS);
  localparam logic [31:0] BURST_C = 32'(SLOT_CLKS) * SLOTS_PER_CYC;
  logic [3:0]  pin_r;
  logic [15:0] per_r;
  logic [7:0]  cyc_r;
  logic        lat_r;
  logic        brst_r;
  logic [31:0] cnt_r;
  wire         go_w = wr_en && addr == OFS_CMD && !busy && |wr_data[1:0];
  // Operands are mirrored only while idle, since busy writes are dropped.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      {pin_r, per_r, cyc_r, lat_r, brst_r, cnt_r} <= '0;
    end else begin
      if (wr_en && !busy && addr == OFS_PIN) pin_r <= wr_data[3:0];
      if (wr_en && !busy && addr == OFS_PERIOD) per_r <= wr_data[15:0];
      if (wr_en && !busy && addr == OFS_CYCLES) cyc_r <= wr_data[7:0];
      if (go_w) begin
        cnt_r <= 32'h1;
        brst_r <= !wr_data[0];
        lat_r <= pin_out[pin_r];
      end else if (busy) begin
        cnt_r <= cnt_r + 32'h1;
      end
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  sequence s_pulse;
    go_w && wr_data[0];
  endsequence
  sequence s_settle;
    busy && pin_oe[pin_r] && $stable(pin_out);
  endsequence
  chk_pulse_start: assert property (s_pulse |=> s_settle)
    else $error("pulse start did not drive the latch level");
  chk_prep_hold: assert property (busy && !brst_r && cnt_r > 32'h1
    && cnt_r < PREP_C |-> $stable(pin_out[pin_r]))
    else $error("pin moved during preparation");
  chk_first_flip: assert property (busy && !brst_r && cnt_r == PREP_C
    |-> pin_out[pin_r] == !lat_r)
    else $error("first toggle missing");
  chk_pulse_len: assert property (done && !brst_r |->
    cnt_r == PREP_C + 32'(per_r) * 32'(PULSE_UNIT_CLKS)
    && pin_out[pin_r] == lat_r)
    else $error("pulse length or end level wrong");
  chk_burst_oe: assert property (busy && brst_r |-> pin_oe[pin_r])
    else $error("burst pin not driven");
  chk_burst_start: assert property (go_w && !wr_data[0] |=>
    pin_out[pin_r] == lat_r)
    else $error("burst start did not show the latch level");
  chk_burst_len: assert property (done && brst_r |->
    cnt_r == 32'h1 + 32'(cyc_r) * BURST_C && !pin_oe[pin_r])
    else $error("burst length wrong or pin kept driven");
  chk_done_idle: assert property (done && !go_w |-> !busy ##1 !done)
    else $error("done not a single idle pulse");
  chk_fall_done: assert property ($fell(busy) |-> done)
    else $error("busy fell without done");
endmodule
bind ppd_pin_waveform ppd_checker ppd_checker_i (.ref_clk(ref_clk),
  .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en),
  .rd_en(rd_en), .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out),
  .pin_oe(pin_oe), .busy(busy), .done(done));

// ### bench/ppd_rc_load.sv
// Pin load model: pull-up on every pin, driven level where enabled.
`timescale 1ns/1ps
module ppd_rc_load (
  input  wire logic [15:0] pin_out,  // device drive levels
  input  wire logic [15:0] pin_oe,   // device drive enables
  output logic      [15:0] pin_in    // resolved pin levels
);
  // A released pin floats to the pull-up, so a low latch glitches it.
  assign pin_in = (pin_out & pin_oe) | ~pin_oe;
endmodule

// ### bench/testbench.sv
// Self-checking bench of the pin waveform engine.
`timescale 1ns/1ps
module testbench;
  import ppd_pkg::*;
  logic              ref_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wr_data = '0;
  logic              wr_en = 1'b0;
  logic              rd_en = 1'b0;
  logic [DATA_W-1:0] rd_data;
  logic [15:0]       pin_in, pin_out, pin_oe, lat;
  logic              busy, done, prev;
  logic [31:0]       rng = 32'h74ad;
  logic [31:0]       exp_reg [10];
  logic [31:0]       msk [10] = '{32'h0, 32'h0, 32'hf, 32'hffff, 32'hff,
                                  32'hff, 32'hffff, 32'hffff, 32'h0, 32'h0};
  int                num_errors = 0;
  int                n_compared = 0;
  int                cyc = 0;
  int                t0, ones, flips;
  logic [3:0]        p;
  logic [7:0]        duty;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;
  ppd_pin_waveform ppd_pin_waveform_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .busy(busy), .done(done));
  ppd_rc_load ppd_rc_load_i (.pin_out(pin_out), .pin_oe(pin_oe),
    .pin_in(pin_in));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic b;
    @(posedge ref_clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    #1;
    // Busy is read between edges, so it is the level the write meets.
    b = busy;
    @(posedge ref_clk);
    wr_en <= 1'b0;
    if (!b && msk[a[7:2]] != 32'h0) exp_reg[a[7:2]] = d & msk[a[7:2]];
    if (a == OFS_STATUS && d[1]) exp_reg[1] = 32'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd_en <= 1'b0;
    #1;
    exp_reg[8] = 32'((exp_reg[6] & exp_reg[7]) | ~exp_reg[7] & 32'hffff);
    chk($sformatf("reg %h", a), exp_reg[a[7:2]], rd_data);
  endtask
  task automatic go(input logic [31:0] c);
    wr(OFS_CMD, c);
    #1;
    t0 = cyc;
  endtask
  task automatic wait_done(input int n);
    int k;
    k = 0;
    while (done !== 1'b1 && k < 60000) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk("done cycle", 32'(n), 32'(cyc - t0));
    exp_reg[1] = 32'h2;
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #(CLK_PERIOD_NS * 70000);
    num_errors++;
    close_out;
  end
  initial begin
    for (int i = 0; i < 10; i++) exp_reg[i] = 32'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) rd(8'(4 * i));
    rng = xs(rng);
    {lat, p} = rng[19:0];
    wr(OFS_PIN, 32'(p));
    for (int i = 0; i < 2; i++) begin
      wr(OFS_PERIOD, 32'(1 - i));
      wr(OFS_OUT, 32'(lat));
      wr(OFS_DIR, 32'h0);
      go(32'h3);
      @(posedge ref_clk);
      #1;
      chk("pin_oe", 1'b1, pin_oe[p]);
      chk("pin_out", lat[p], pin_out[p]);
      wr(OFS_PERIOD, 32'h5);
      wr(OFS_CMD, 32'h2);
      wait_done(int'(PREP_CLKS) + int'(PULSE_UNIT_CLKS) * (1 - i));
      chk("end level", lat[p], pin_out[p]);
      exp_reg[7] = 32'(16'h1 << p);
      rd(OFS_PERIOD);
      rd(OFS_DIR);
      rd(OFS_LEVEL);
      wr(OFS_STATUS, 32'h2);
      rd(OFS_STATUS);
      lat = ~lat;
    end
    rng = xs(rng);
    duty = rng[7:0];
    wr(OFS_DUTY, 32'(duty));
    wr(OFS_CYCLES, 32'h1);
    go(32'h2);
    chk("burst oe on", 1'b1, pin_oe[p]);
    chk("burst first", !lat[p], pin_out[p]);
    ones = 0;
    flips = 0;
    for (int k = 0; k < SLOTS_PER_CYC; k++) begin
      while (cyc - t0 < 2 + int'(SLOT_CLKS) * k + int'(SLOT_CLKS) / 2) begin
        @(posedge ref_clk);
        #1;
      end
      ones += int'(pin_out[p] === 1'b1);
      flips += int'(k > 0 && pin_out[p] !== prev);
      prev = pin_out[p];
    end
    chk("ones", 32'(duty), 32'(ones));
    chk("flips", 1'b1, flips >= (duty[7] ? 255 - int'(duty) : int'(duty)));
    wait_done(int'(SLOT_CLKS) * SLOTS_PER_CYC);
    chk("burst oe", 1'b0, pin_oe[p]);
    chk("burst latch", !lat[p], pin_out[p]);
    wr(OFS_CYCLES, 32'h0);
    wr(OFS_DIR, 32'(16'h1 << p));
    go(32'h2);
    wait_done(0);
    exp_reg[7] = 32'h0;
    rd(OFS_DIR);
    close_out;
  end
endmodule
